//--- verilog/pdcfg_pkg.sv
package pdcfg_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [9:0] DET_CTRL_INDEX = 10'h00B;
	localparam logic [9:0] EXACT_FREQ_INDEX = 10'h00C;

	localparam int REG_W = 24;
	localparam logic [23:0] DET_CTRL_RESET = 24'h07C061;
	localparam logic [23:0] EXACT_FREQ_RESET = 24'h000000;

	// Field positions of the detector control register.
	localparam int DELAY_LSB = 0;
	localparam int SHORT_BIT = 3;
	localparam int POLARITY_BIT = 4;
	localparam int RAISE_EN_BIT = 5;
	localparam int LOWER_EN_BIT = 6;
	localparam int GUARD_LSB = 7;
	localparam int PUMP_RAISE_BIT = 9;
	localparam int PUMP_LOWER_BIT = 10;
	localparam int MIDRAIL_BIT = 11;
	localparam int RSV_LOW_LSB = 12;
	localparam int BIAS_LSB = 15;
	localparam int GATING_LSB = 17;
	localparam int RSV_HIGH_LSB = 19;

	// Exact frequency register.
	localparam int CHAN_W = 14;
	localparam int CHAN_LSB = 0;
	localparam logic [13:0] CHAN_MIN_ENABLED = 14'h0002;

	// Divider counter gating codes.
	localparam logic [1:0] GATING_OFF = 2'h0;
	localparam logic [1:0] GATING_ALL_ON = 2'h3;

	// Cycle slip guard thresholds, in picoseconds, and the clock period.
	localparam int CLOCK_PERIOD_PS = 4000;
	localparam int GUARD_NEAR_PS = 5400;
	localparam int GUARD_MID_PS = 14400;
	localparam int GUARD_FAR_PS = 24100;
	localparam int GUARD_CNT_W = 4;
	localparam int GUARD_NEAR_INT = (GUARD_NEAR_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int GUARD_MID_INT = (GUARD_MID_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int GUARD_FAR_INT = (GUARD_FAR_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam logic [3:0] GUARD_NEAR_CYCLES = GUARD_NEAR_INT[3:0];
	localparam logic [3:0] GUARD_MID_CYCLES = GUARD_MID_INT[3:0];
	localparam logic [3:0] GUARD_FAR_CYCLES = GUARD_FAR_INT[3:0];

	// AHB-Lite encodings.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [2:0] HSIZE_HALF = 3'h1;

	typedef struct packed {
		logic [1:0] reservedTop;
		logic [1:0] reservedUpper;
		logic reservedSingle;
		logic [1:0] dividerCounterGating;
		logic [1:0] pumpAmpBias;
		logic [2:0] reservedLow;
		logic pumpMidrailForce;
		logic pumpLowerForce;
		logic pumpRaiseForce;
		logic [1:0] cycleSlipGuardSelect;
		logic detectorLowerOutputEnable;
		logic detectorRaiseOutputEnable;
		logic detectorPolarityInvert;
		logic detectorInputsShort;
		logic [2:0] detectorResetDelaySelect;
	} detector_ctrl_t;

	typedef struct packed {
		logic pumpRaise;
		logic pumpLower;
		logic pumpMidrail;
		logic slipBoost;
	} pump_drive_t;

	typedef struct packed {
		logic exactModeEnable;
		logic [13:0] channelCount;
		logic correctionStrobe;
		logic dividerRun;
		logic [1:0] dividerRange;
	} synth_status_t;

endpackage

//--- verilog/slip_width_monitor.sv
`timescale 1ns/1ps
module slip_width_monitor #(
	parameter int CNT_W = 4
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic active,
	input wire logic enable,
	input wire logic [CNT_W-1:0] limit,
	output logic over
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic over;
	} mon_state_t;

	mon_state_t state_r;
	mon_state_t state_nxt;

	// The counter saturates so a very long error pulse cannot wrap back under the limit.
	always_comb begin
		state_nxt = state_r;
		if (active) begin
			if (state_r.count != {CNT_W{1'b1}}) begin
				state_nxt.count = state_r.count + 1'b1;
			end
		end else begin
			state_nxt.count = '0;
		end
		state_nxt.over = enable && active && (state_nxt.count >= limit);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign over = state_r.over;
endmodule // slip_width_monitor

//--- verilog/phase_detector_config_regs.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module phase_detector_config_regs (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic detectorRaiseIn,
	input wire logic detectorLowerIn,
	input wire logic comparisonTick,
	output pdcfg_pkg::detector_ctrl_t detectorControl,
	output pdcfg_pkg::pump_drive_t pumpDrive,
	output pdcfg_pkg::synth_status_t synthStatus
);
	import pdcfg_pkg::*;

	typedef struct packed {
		logic pendWrite;
		logic [9:0] pendIndex;
		logic [23:0] pendMask;
		detector_ctrl_t detCtrl;
		logic [23:0] exactReg;
		logic [31:0] readData;
		pump_drive_t pump;
		logic [13:0] corrCount;
		synth_status_t status;
	} cfg_state_t;

	cfg_state_t state_r;
	cfg_state_t state_nxt;

	logic addrPhase;
	logic [23:0] laneMask;
	logic [23:0] writeMerged;
	logic effRaise;
	logic effLower;
	logic swRaise;
	logic swLower;
	logic guardOn;
	logic [3:0] guardLimit;
	logic raiseOver;
	logic lowerOver;
	logic [13:0] chanCount;

	assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

	// Byte lanes follow hsize and the low address bits, so narrow writes stay legal.
	always_comb begin
		laneMask = '0;
		case (hsize)
			HSIZE_BYTE: begin
				case (haddr[1:0])
					2'h0: laneMask = 24'h0000FF;
					2'h1: laneMask = 24'h00FF00;
					2'h2: laneMask = 24'hFF0000;
					default: laneMask = 24'h000000;
				endcase
			end
			HSIZE_HALF: begin
				laneMask = haddr[1] ? 24'hFF0000 : 24'h00FFFF;
			end
			default: begin
				laneMask = 24'hFFFFFF;
			end
		endcase
	end

	assign writeMerged = hwdata[23:0] & state_r.pendMask;

	// With the inputs shorted the detector sees no phase error at all.
	// inputs shorted
	assign effRaise = state_r.detCtrl.detectorInputsShort ? 1'b0 : detectorRaiseIn;
	assign effLower = state_r.detCtrl.detectorInputsShort ? 1'b0 : detectorLowerIn;

	assign swRaise = state_r.detCtrl.detectorPolarityInvert ? effLower : effRaise;
	assign swLower = state_r.detCtrl.detectorPolarityInvert ? effRaise : effLower;

	always_comb begin
		guardOn = 1'b1;
		guardLimit = GUARD_FAR_CYCLES;
		case (state_r.detCtrl.cycleSlipGuardSelect)
			2'h0: begin
				guardOn = 1'b0;
				guardLimit = GUARD_FAR_CYCLES;
			end
			2'h1: guardLimit = GUARD_NEAR_CYCLES;
			2'h2: guardLimit = GUARD_MID_CYCLES;
			default: guardLimit = GUARD_FAR_CYCLES;
		endcase
	end

	slip_width_monitor #(
		.CNT_W(GUARD_CNT_W)
	) raiseMonitor (
		.clock(clock),
		.reset_n(reset_n),
		.active(swRaise),
		.enable(guardOn),
		.limit(guardLimit),
		.over(raiseOver)
	);

	slip_width_monitor #(
		.CNT_W(GUARD_CNT_W)
	) lowerMonitor (
		.clock(clock),
		.reset_n(reset_n),
		.active(swLower),
		.enable(guardOn),
		.limit(guardLimit),
		.over(lowerOver)
	);

	always_comb begin
		state_nxt = state_r;
		chanCount = '0;

		if (state_r.pendWrite) begin
			case (state_r.pendIndex)
				DET_CTRL_INDEX: begin
					state_nxt.detCtrl = (state_r.detCtrl & ~state_r.pendMask) | writeMerged;
				end
				EXACT_FREQ_INDEX: begin
					state_nxt.exactReg = (state_r.exactReg & ~state_r.pendMask) | writeMerged;
				end
				default: begin
					state_nxt.exactReg = state_r.exactReg;
				end
			endcase
		end

		state_nxt.pendWrite = addrPhase && hwrite;
		if (addrPhase) begin
			state_nxt.pendIndex = haddr[11:2];
			state_nxt.pendMask = laneMask;
		end

		// Read data is taken from the next-state copy, so a read right after a write sees it.
		if (addrPhase && !hwrite) begin
			case (haddr[11:2])
				DET_CTRL_INDEX: state_nxt.readData = {8'h00, state_nxt.detCtrl};
				EXACT_FREQ_INDEX: state_nxt.readData = {8'h00, state_nxt.exactReg};
				default: state_nxt.readData = 32'h00000000;
			endcase
		end

		if (state_r.detCtrl.pumpMidrailForce) begin
			state_nxt.pump.pumpRaise = 1'b0;
			state_nxt.pump.pumpLower = 1'b0;
		end else begin
			state_nxt.pump.pumpRaise = state_r.detCtrl.pumpRaiseForce ||
				(state_r.detCtrl.detectorRaiseOutputEnable && swRaise);
			state_nxt.pump.pumpLower = state_r.detCtrl.pumpLowerForce ||
				(state_r.detCtrl.detectorLowerOutputEnable && swLower);
		end
		state_nxt.pump.pumpMidrail = state_r.detCtrl.pumpMidrailForce;
		state_nxt.pump.slipBoost = (raiseOver && state_r.detCtrl.detectorRaiseOutputEnable) ||
			(lowerOver && state_r.detCtrl.detectorLowerOutputEnable);

		chanCount = state_r.exactReg[CHAN_LSB +: CHAN_W];
		state_nxt.status.channelCount = chanCount;
		state_nxt.status.exactModeEnable = chanCount >= CHAN_MIN_ENABLED;
		state_nxt.status.correctionStrobe = 1'b0;
		if (chanCount < CHAN_MIN_ENABLED) begin
			state_nxt.corrCount = '0;
		end else if (comparisonTick) begin
			if (state_r.corrCount >= chanCount - 14'h0001) begin
				state_nxt.corrCount = '0;
				state_nxt.status.correctionStrobe = 1'b1;
			end else begin
				state_nxt.corrCount = state_r.corrCount + 14'h0001;
			end
		end

		state_nxt.status.dividerRun = state_r.detCtrl.dividerCounterGating != GATING_OFF;
		state_nxt.status.dividerRange = state_r.detCtrl.dividerCounterGating;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r.pendWrite <= 1'b0;
			state_r.pendIndex <= '0;
			state_r.pendMask <= '0;
			state_r.detCtrl <= DET_CTRL_RESET;
			state_r.exactReg <= EXACT_FREQ_RESET;
			state_r.readData <= '0;
			state_r.pump <= '0;
			state_r.corrCount <= '0;
			state_r.status.exactModeEnable <= 1'b0;
			state_r.status.channelCount <= '0;
			state_r.status.correctionStrobe <= 1'b0;
			state_r.status.dividerRun <= 1'b1;
			state_r.status.dividerRange <= GATING_ALL_ON;
		end else begin
			state_r <= state_nxt;
		end
	end

	// The slave never stretches a transfer and always answers OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = state_r.readData;
	assign detectorControl = state_r.detCtrl;
	assign pumpDrive = state_r.pump;
	assign synthStatus = state_r.status;
endmodule // phase_detector_config_regs

//--- sim/pd_cfg_checker.sv
`timescale 1ns/1ps
module pd_cfg_checker (
	input wire logic clock,
	input wire logic reset_n,
	input wire pdcfg_pkg::detector_ctrl_t detectorControl,
	input wire pdcfg_pkg::pump_drive_t pumpDrive,
	input wire pdcfg_pkg::synth_status_t synthStatus
);
	import pdcfg_pkg::*;
	detector_ctrl_t c;
	pump_drive_t p;
	assign c = detectorControl;
	assign p = pumpDrive;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	chk_reset_default: assert property ($rose(reset_n) |-> c == DET_CTRL_RESET)
		else $error("control not at default");
	chk_raise_gate: assert property (!c.detectorRaiseOutputEnable && !c.pumpRaiseForce |=> !p.pumpRaise)
		else $error("raise not gated");
	chk_lower_gate: assert property (!c.detectorLowerOutputEnable && !c.pumpLowerForce |=> !p.pumpLower)
		else $error("lower not gated");
	chk_force_pump: assert property (!c.pumpMidrailForce |=> p.pumpRaise >= $past(c.pumpRaiseForce)
		&& p.pumpLower >= $past(c.pumpLowerForce)) else $error("force ignored");
	chk_midrail_park: assert property (c.pumpMidrailForce |=> p.pumpMidrail && !p.pumpRaise && !p.pumpLower)
		else $error("midrail not parked");
	chk_short_quiet: assert property (c.detectorInputsShort && !c.pumpRaiseForce && !c.pumpLowerForce
		|=> !p.pumpRaise && !p.pumpLower) else $error("shorted inputs drive pump");
	chk_guard_off: assert property (c.cycleSlipGuardSelect == 2'h0 [*3] |=> !p.slipBoost)
		else $error("boost while guard off");
	chk_exact_mode: assert property (synthStatus.exactModeEnable == (synthStatus.channelCount >= 14'h0002))
		else $error("exact mode wrong");
	chk_gating_follow: assert property (synthStatus.dividerRange == $past(c.dividerCounterGating)
		&& synthStatus.dividerRun == ($past(c.dividerCounterGating) != 2'h0)) else $error("gating wrong");
	cover property (c.cycleSlipGuardSelect != 2'h0 ##1 p.slipBoost);
	cover property (synthStatus.correctionStrobe);
	cover property (c.pumpMidrailForce ##1 p.pumpMidrail);
endmodule // pd_cfg_checker

bind phase_detector_config_regs pd_cfg_checker chk (.clock(clock), .reset_n(reset_n),
	.detectorControl(detectorControl), .pumpDrive(pumpDrive), .synthStatus(synthStatus));

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import pdcfg_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, rIn = 1'b0, lIn = 1'b0, tick = 1'b0;
	logic [31:0] hrdata, q, d, e, s = 32'hA;
	detector_ctrl_t dc;
	pump_drive_t pd;
	synth_status_t ss;
	int n_mismatch = 0, n_checks = 0, k, ns;
	int ps [3] = '{5400, 14400, 24100};
	logic [13:0] corner [4] = '{14'h0000, 14'h0001, 14'h0002, 14'h3FFF};
	phase_detector_config_regs dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .detectorRaiseIn(rIn),
		.detectorLowerIn(lIn), .comparisonTick(tick), .detectorControl(dc), .pumpDrive(pd),
		.synthStatus(ss));
	initial begin
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		if (ss.correctionStrobe === 1'b1) ns++;
	end
	function automatic logic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	function automatic logic [2:0] pumpExp(logic [23:0] c, logic r, logic l);
		logic a, b;
		a = r & ~c[3];
		b = l & ~c[3];
		{a, b} = c[4] ? {b, a} : {a, b};
		return c[11] ? 3'h1 : {(a & c[5]) | c[9], (b & c[6]) | c[10], 1'b0};
	endfunction
	task results();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// A bounded wait, so a stuck slave ends the run instead of hanging it.
	task waitReady();
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_mismatch++;
			results();
		end
	endtask
	task bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {20'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		waitReady();
		htrans <= 2'h0;
		hwdata <= wd;
		waitReady();
		q = hrdata;
		cmp("hresp", 32'h0, {31'h0, hresp});
	endtask
	initial begin
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		bus(1'b0, DET_CTRL_INDEX, 32'h0);
		cmp("ctrl reset", {8'h0, DET_CTRL_RESET}, q);
		bus(1'b0, EXACT_FREQ_INDEX, 32'h0);
		cmp("freq reset", 32'h0, q);
		for (int i = 0; i < 24; i++) begin
			d = rnd();
			e = rnd();
			if (i < 4) d[13:0] = corner[i];
			e[23:12] = {5'h00, e[18:17], 5'h1C};
			bus(1'b1, EXACT_FREQ_INDEX, d);
			bus(1'b1, DET_CTRL_INDEX, e);
			bus(1'b0, EXACT_FREQ_INDEX, 32'h0);
			cmp("freq", {18'h0, d[13:0]}, {18'h0, q[13:0]});
			cmp("mode", {31'h0, d[13:0] >= 14'h0002}, {31'h0, ss.exactModeEnable});
			cmp("chan", {18'h0, d[13:0]}, {18'h0, ss.channelCount});
			bus(1'b0, DET_CTRL_INDEX, 32'h0);
			cmp("ctrl", {8'h0, e[23:0]}, q);
			cmp("gating", {30'h0, e[18:17]}, {30'h0, ss.dividerRange});
			cmp("div run", {31'h0, e[18:17] != 2'h0}, {31'h0, ss.dividerRun});
		end
		bus(1'b1, 10'h00D, 32'hFFFFFF);
		bus(1'b0, 10'h00D, 32'h0);
		cmp("unmapped", 32'h0, q);
		// A byte write must touch only its own lane.
		bus(1'b1, EXACT_FREQ_INDEX, 32'h00123456);
		@(posedge clock);
		hsize <= HSIZE_BYTE;
		bus(1'b1, EXACT_FREQ_INDEX, 32'h000000AB);
		hsize <= 3'h2;
		bus(1'b0, EXACT_FREQ_INDEX, 32'h0);
		cmp("byte lane", 32'h001234AB, q);
		for (int i = 0; i < 32; i++) begin
			d = rnd();
			@(posedge clock);
			{rIn, lIn} <= d[1:0];
			e = 32'((DET_CTRL_RESET & ~24'h000E78) | (d[23:0] & 24'h000E78));
			bus(1'b1, DET_CTRL_INDEX, e);
			repeat (2) @(negedge clock);
			cmp("pump", {29'h0, pumpExp(e[23:0], d[1], d[0])}, {29'h0, pd[3:1]});
		end
		for (int g = 1; g < 4; g++) begin
			@(posedge clock);
			{rIn, lIn} <= 2'h0;
			bus(1'b1, DET_CTRL_INDEX, 32'(DET_CTRL_RESET) | (32'(g) << 7));
			repeat (4) @(negedge clock);
			@(posedge clock);
			rIn <= 1'b1;
			repeat ((ps[g - 1] + 3999) / 4000) @(negedge clock);
			cmp("slip early", 32'h0, {31'h0, pd.slipBoost});
			repeat (5) @(negedge clock);
			cmp("slip late", 32'h1, {31'h0, pd.slipBoost});
		end
		for (int n = 1; n < 4; n += 2) begin
			bus(1'b1, EXACT_FREQ_INDEX, 32'h1);
			bus(1'b1, EXACT_FREQ_INDEX, 32'(n));
			ns = 0;
			repeat (9) begin
				@(posedge clock);
				tick <= 1'b1;
				@(posedge clock);
				tick <= 1'b0;
			end
			repeat (3) @(posedge clock);
			cmp("strobes", (n >= 2) ? 32'(9 / n) : 32'h0, 32'(ns));
		end
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		@(negedge clock);
		cmp("ctrl again", {8'h0, DET_CTRL_RESET}, {8'h0, dc});
		bus(1'b0, EXACT_FREQ_INDEX, 32'h0);
		cmp("freq again", {8'h0, EXACT_FREQ_RESET}, q);
		results();
	end
endmodule // testbench
